// ===== logic/aic_defines.vh
// Purpose: Shared constants of the analog input channel filter
// Assumes: Byte addresses on a 32-bit AXI4-Lite register bus
// Notes: Times are kept in their own unit; cycle counts derive from them
`ifndef AIC_DEFINES_VH
`define AIC_DEFINES_VH

// Register byte offsets
`define REG_CONTROL 8'h00
`define REG_SCAN_INTERVAL 8'h04
`define REG_SCALE_LOW 8'h08
`define REG_SCALE_HIGH 8'h0c
`define REG_COMMAND 8'h10
`define REG_SLOT_BUS 8'h14
`define REG_ATTEMPTS 8'h18
`define REG_SUCCESSES 8'h1c
`define REG_DRIVER_FAILS 8'h20
`define REG_FAULT_RANGE 8'h24
`define REG_RAW 8'h28
`define REG_FILTERED 8'h2c
`define REG_SCALED 8'h30
`define REG_QUALITY 8'h34
`define REG_FAULT_BITS 8'h38
`define REG_LAST_SCAN 8'h3c

// Control register fields
`define CTL_STATE_LSB 0
`define CTL_FILTER_LSB 2
`define CTL_KIND_BIT 4
`define CTL_COUNT_LSB 8
`define CTL_RESET 32'h0000_0101

// Encodings
`define CHAN_DISABLED 2'h1
`define CHAN_ENABLED 2'h2
`define FILT_MEDIAN 2'h0
`define FILT_AVERAGE 2'h1
`define FILT_LAG 2'h2
`define CMD_RESET_CHANNEL 32'h0000_0001
`define CMD_RESET_ALARM 32'h0000_0002
`define RES_NONE 3'h0
`define RES_START 3'h1
`define RES_COMPLETE 3'h2
`define RES_ERROR 3'h3
`define RES_EXECUTING 3'h4
`define RES_INVALID 3'h5
`define RES_TIMEOUT 3'h6
`define SLOT_BUS_ANALOG 32'h0000_0009
`define Q_GOOD 2'h0
`define Q_SENSOR_FAIL 2'h1
`define Q_OUT_OF_SERVICE 2'h2
`define Q_OUT_OF_RANGE 2'h3

// Fault bitmap
`define FB_UNDER 32'h0000_0800
`define FB_OVER 32'h0000_1000
`define FB_CAL 32'h0000_2000
`define FB_DISABLED 32'h0000_0020
`define FB_NOT_INSTALLED 32'h0100_0000

// Timing
`define CLK_PERIOD_NS 50
`define TICK_PERIOD_MS 1
`define SCAN_DEFAULT_MS 16'd100
`define SCAN_MIN_MS 16'd100
`define SCAN_MAX_MS 16'd60000
`define RANGE_HOLD_S 4
`define RANGE_HOLD_MS (`RANGE_HOLD_S * 1000)
`define TICK_CYCLES (`TICK_PERIOD_MS * 1000000 / `CLK_PERIOD_NS)

`endif

// ===== logic/analog_input_channel_filter.v
// Purpose: Scan, filter, scale and qualify one analog input channel
// Assumes: Sample handshake partner runs on aclk; presence and calibration are pins
// Notes: Registers over AXI4-Lite; one millisecond tick drives all timing
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "aic_defines.vh"

module analog_input_channel_filter #(
    parameter CNT_W = 32,
    parameter TICK_CYCLES = `TICK_CYCLES,
    parameter RANGE_HOLD_MS = `RANGE_HOLD_MS,
    parameter [23:0] CUR_4MA = 24'd4000,
    parameter [23:0] CUR_20MA = 24'd20000,
    parameter [23:0] CUR_3P6MA = 24'd3600,
    parameter [23:0] CUR_21MA = 24'd21000,
    parameter [23:0] VOLT_LO = 24'd0,
    parameter [23:0] VOLT_HI = 24'd10000
) (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg sample_req,
    input wire sample_done,
    input wire sample_ok,
    input wire [23:0] sample_data,
    input wire module_present_pin,
    input wire cal_error_pin
);

    localparam S_IDLE = 2'd0;
    localparam S_WAIT = 2'd1;
    localparam S_FILT = 2'd2;
    localparam S_SCALE = 2'd3;

    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0] strb;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (strb[b]) begin
                    merge[b*8 +: 8] = data[b*8 +: 8];
                end
            end
        end
    endfunction

    function [15:0] clamp_interval;
        input [15:0] ms;
        begin
            if (ms < `SCAN_MIN_MS) begin
                clamp_interval = `SCAN_MIN_MS;
            end else if (ms > `SCAN_MAX_MS) begin
                clamp_interval = `SCAN_MAX_MS;
            end else begin
                clamp_interval = ms;
            end
        end
    endfunction

    // Configuration and state
    reg [31:0] control;
    reg [15:0] scan_interval;
    reg [31:0] scale_low;
    reg [31:0] scale_high;
    reg [2:0] command_result;
    reg [1:0] cmd_stage;
    reg [31:0] cmd_code;
    reg [CNT_W-1:0] read_attempt_count;
    reg [CNT_W-1:0] read_success_count;
    reg [CNT_W-1:0] driver_fail_count;
    reg [CNT_W-1:0] fault_range_count;
    reg [23:0] raw_sample;
    reg [23:0] filtered_sample;
    reg [31:0] scaled_value;
    reg [31:0] last_scan_time;
    reg [31:0] ms_time;
    reg [15:0] ms_since;
    reg [31:0] tick_div;
    reg ms_tick;
    reg [15:0] under_ms;
    reg [15:0] over_ms;
    reg under_range;
    reg over_range;
    reg [1:0] state;
    reg [3:0] fill;
    reg [23:0] sbuf [0:7];
    reg present_meta, present_sync, cal_meta, cal_sync;
    reg aw_held, w_held;
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;

    wire [1:0] channel_state = control[`CTL_STATE_LSB +: 2];
    wire [1:0] filter_select = control[`CTL_FILTER_LSB +: 2];
    wire input_kind = control[`CTL_KIND_BIT];
    wire [3:0] sample_count = control[`CTL_COUNT_LSB +: 4];
    wire enabled = (channel_state == `CHAN_ENABLED);
    wire [15:0] interval_eff = clamp_interval(scan_interval);

    // Synchronise pin levels before use
    always @(posedge aclk) begin
        if (!aresetn) begin
            present_meta <= 1'b0;
            present_sync <= 1'b0;
            cal_meta <= 1'b0;
            cal_sync <= 1'b0;
        end else begin
            present_meta <= module_present_pin;
            present_sync <= present_meta;
            cal_meta <= cal_error_pin;
            cal_sync <= cal_meta;
        end
    end

    // Filter arithmetic over the first sample_count entries, index 0 newest
    reg [3:0] rank [0:7];
    reg [23:0] med_a, med_b;
    reg [26:0] sum;
    reg [31:0] wsum;
    reg [23:0] filt_next;
    reg [5:0] wtotal;
    reg [26:0] avg_q;
    reg [31:0] lag_q;
    reg [24:0] mid_sum;
    integer i, j, k;

    always @* begin
        sum = 27'd0;
        wsum = 32'd0;
        med_a = 24'd0;
        med_b = 24'd0;
        for (i = 0; i < 8; i = i + 1) begin
            rank[i] = 4'd0;
            for (j = 0; j < 8; j = j + 1) begin
                if (j < sample_count && j != i && (sbuf[j] < sbuf[i] ||
                        (sbuf[j] == sbuf[i] && j < i))) begin
                    rank[i] = rank[i] + 4'd1;
                end
            end
        end
        for (i = 0; i < 8; i = i + 1) begin
            if (i < sample_count) begin
                sum = sum + {3'd0, sbuf[i]};
                // Oldest entry carries weight 1, newest weight sample_count
                wsum = wsum + sbuf[i] * (sample_count - i[3:0]);
                if (rank[i] == ((sample_count - 4'd1) >> 1)) begin
                    med_a = sbuf[i];
                end
                if (rank[i] == (sample_count >> 1)) begin
                    med_b = sbuf[i];
                end
            end
        end
        wtotal = ({2'd0, sample_count} * ({2'd0, sample_count} + 6'd1)) >> 1;
        avg_q = sum / sample_count;
        lag_q = wsum / wtotal;
        mid_sum = {1'b0, med_a} + {1'b0, med_b};
        case (filter_select)
            `FILT_AVERAGE: filt_next = avg_q[23:0];
            `FILT_LAG: filt_next = lag_q[23:0];
            default: filt_next = mid_sum[24:1];
        endcase
    end

    // Linear scaling, no clamp at either end
    wire [23:0] span_lo = input_kind ? CUR_4MA : VOLT_LO;
    wire [23:0] span_hi = input_kind ? CUR_20MA : VOLT_HI;
    wire signed [63:0] pos_off = $signed({40'd0, filtered_sample}) - $signed({40'd0, span_lo});
    wire signed [63:0] out_span = $signed({{32{scale_high[31]}}, scale_high}) -
        $signed({{32{scale_low[31]}}, scale_low});
    wire signed [63:0] in_span = $signed({40'd0, span_hi}) - $signed({40'd0, span_lo});
    wire signed [63:0] scaled_off = (pos_off * out_span) / in_span;
    wire [31:0] scaled_next = scale_low + scaled_off[31:0];

    // Quality codes, sensor failure outranks out of service
    wire range_bad = under_range | over_range;
    wire [1:0] base_q = !present_sync ? `Q_SENSOR_FAIL :
        (!enabled ? `Q_OUT_OF_SERVICE : `Q_GOOD);
    wire [1:0] raw_q = base_q;
    wire [1:0] filt_q = (base_q == `Q_GOOD && range_bad) ? `Q_OUT_OF_RANGE : base_q;
    wire [1:0] scaled_q = (base_q == `Q_GOOD && (range_bad || cal_sync)) ?
        `Q_OUT_OF_RANGE : base_q;
    wire [31:0] point_fault_bits = (under_range ? `FB_UNDER : 32'h0) |
        (over_range ? `FB_OVER : 32'h0) | (cal_sync ? `FB_CAL : 32'h0) |
        (!enabled ? `FB_DISABLED : 32'h0) | (!present_sync ? `FB_NOT_INSTALLED : 32'h0);

    wire cmd_fire = (cmd_stage == 2'd2);
    wire reset_chan = cmd_fire && (cmd_code == `CMD_RESET_CHANNEL);
    wire reset_alarm = cmd_fire && (cmd_code == `CMD_RESET_ALARM);
    wire raw_fault = (sample_data < CUR_3P6MA) || (sample_data > CUR_21MA);

    // Millisecond tick and timestamps
    always @(posedge aclk) begin
        if (!aresetn) begin
            tick_div <= 32'd0;
            ms_tick <= 1'b0;
            ms_time <= 32'd0;
        end else begin
            ms_tick <= 1'b0;
            if (tick_div == TICK_CYCLES - 1) begin
                tick_div <= 32'd0;
                ms_tick <= 1'b1;
            end else begin
                tick_div <= tick_div + 32'd1;
            end
            if (ms_tick) begin
                ms_time <= ms_time + 32'd1;
            end
        end
    end

    // Scan sequencer, sample buffer and counters
    always @(posedge aclk) begin
        if (!aresetn || reset_chan) begin
            state <= S_IDLE;
            fill <= 4'd0;
            sample_req <= 1'b0;
            ms_since <= 16'd0;
            read_attempt_count <= {CNT_W{1'b0}};
            read_success_count <= {CNT_W{1'b0}};
            driver_fail_count <= {CNT_W{1'b0}};
            fault_range_count <= {CNT_W{1'b0}};
            raw_sample <= 24'd0;
            filtered_sample <= 24'd0;
            scaled_value <= 32'd0;
            last_scan_time <= 32'd0;
            for (k = 0; k < 8; k = k + 1) begin
                sbuf[k] <= 24'd0;
            end
        end else begin
            sample_req <= 1'b0;
            if (ms_tick && ms_since != 16'hffff) begin
                ms_since <= ms_since + 16'd1;
            end
            case (state)
                S_IDLE: begin
                    if (enabled && present_sync && ms_since >= interval_eff) begin
                        sample_req <= 1'b1;
                        ms_since <= 16'd0;
                        last_scan_time <= ms_time;
                        read_attempt_count <= read_attempt_count + 1'b1;
                        state <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (sample_done) begin
                        state <= S_IDLE;
                        if (sample_ok) begin
                            read_success_count <= read_success_count + 1'b1;
                            raw_sample <= sample_data;
                            if (raw_fault) begin
                                fault_range_count <= fault_range_count + 1'b1;
                            end
                            sbuf[0] <= sample_data;
                            for (k = 1; k < 8; k = k + 1) begin
                                sbuf[k] <= sbuf[k-1];
                            end
                            if (fill + 4'd1 >= sample_count) begin
                                fill <= 4'd0;
                                state <= S_FILT;
                            end else begin
                                fill <= fill + 4'd1;
                            end
                        end else begin
                            driver_fail_count <= driver_fail_count + 1'b1;
                        end
                    end
                end
                S_FILT: begin
                    filtered_sample <= filt_next;
                    state <= S_SCALE;
                end
                default: begin
                    scaled_value <= scaled_next;
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // Range persistence timers; a flag rising in a clearing cycle is kept, so set wins
    wire under_hit = (filtered_sample < CUR_3P6MA) && ms_tick && !under_range &&
        (under_ms >= RANGE_HOLD_MS - 1);
    wire over_hit = (filtered_sample > CUR_21MA) && ms_tick && !over_range &&
        (over_ms >= RANGE_HOLD_MS - 1);
    always @(posedge aclk) begin
        if (!aresetn) begin
            under_ms <= 16'd0;
            over_ms <= 16'd0;
            under_range <= 1'b0;
            over_range <= 1'b0;
        end else if (reset_chan || reset_alarm) begin
            under_ms <= 16'd0;
            over_ms <= 16'd0;
            under_range <= under_hit;
            over_range <= over_hit;
        end else begin
            if (filtered_sample >= CUR_3P6MA) begin
                under_ms <= 16'd0;
                under_range <= 1'b0;
            end else if (ms_tick) begin
                if (under_ms >= RANGE_HOLD_MS - 1) begin
                    under_range <= 1'b1;
                end else begin
                    under_ms <= under_ms + 16'd1;
                end
            end
            if (filtered_sample <= CUR_21MA) begin
                over_ms <= 16'd0;
                over_range <= 1'b0;
            end else if (ms_tick) begin
                if (over_ms >= RANGE_HOLD_MS - 1) begin
                    over_range <= 1'b1;
                end else begin
                    over_ms <= over_ms + 16'd1;
                end
            end
        end
    end

    // AXI4-Lite write channel and configuration registers
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire [31:0] interval_word = merge({16'd0, scan_interval}, w_data, w_strb);
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            control <= `CTL_RESET;
            scan_interval <= `SCAN_DEFAULT_MS;
            scale_low <= 32'h0;
            scale_high <= 32'h0;
            command_result <= `RES_NONE;
            cmd_stage <= 2'd0;
            cmd_code <= 32'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            // Command sequence: start, executing, then complete
            if (cmd_stage == 2'd1) begin
                command_result <= `RES_EXECUTING;
                cmd_stage <= 2'd2;
            end else if (cmd_stage == 2'd2) begin
                command_result <= `RES_COMPLETE;
                cmd_stage <= 2'd0;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'b00;
                if (aw_addr[7:2] == `REG_CONTROL >> 2) begin
                    control <= merge(control, w_data, w_strb) & 32'h0000_0f1f;
                end else if (aw_addr[7:2] == `REG_SCAN_INTERVAL >> 2) begin
                    scan_interval <= interval_word[15:0];
                end else if (aw_addr[7:2] == `REG_SCALE_LOW >> 2) begin
                    scale_low <= merge(scale_low, w_data, w_strb);
                end else if (aw_addr[7:2] == `REG_SCALE_HIGH >> 2) begin
                    scale_high <= merge(scale_high, w_data, w_strb);
                end else if (aw_addr[7:2] == `REG_COMMAND >> 2) begin
                    // A command arriving mid-sequence is refused as invalid
                    if ((w_data == `CMD_RESET_CHANNEL || w_data == `CMD_RESET_ALARM) &&
                            cmd_stage == 2'd0) begin
                        cmd_code <= w_data;
                        command_result <= `RES_START;
                        cmd_stage <= 2'd1;
                    end else begin
                        command_result <= `RES_INVALID;
                    end
                end else if (aw_addr[7:2] > `REG_LAST_SCAN >> 2) begin
                    s_axi_bresp <= 2'b10;
                end
            end
        end
    end

    // AXI4-Lite read channel
    reg [31:0] rd_word;
    reg rd_err;
    always @* begin
        rd_err = 1'b0;
        if (s_axi_araddr[7:2] == `REG_CONTROL >> 2) begin
            rd_word = control;
        end else if (s_axi_araddr[7:2] == `REG_SCAN_INTERVAL >> 2) begin
            rd_word = {16'd0, scan_interval};
        end else if (s_axi_araddr[7:2] == `REG_SCALE_LOW >> 2) begin
            rd_word = scale_low;
        end else if (s_axi_araddr[7:2] == `REG_SCALE_HIGH >> 2) begin
            rd_word = scale_high;
        end else if (s_axi_araddr[7:2] == `REG_COMMAND >> 2) begin
            rd_word = {29'd0, command_result};
        end else if (s_axi_araddr[7:2] == `REG_SLOT_BUS >> 2) begin
            rd_word = `SLOT_BUS_ANALOG;
        end else if (s_axi_araddr[7:2] == `REG_ATTEMPTS >> 2) begin
            rd_word = read_attempt_count;
        end else if (s_axi_araddr[7:2] == `REG_SUCCESSES >> 2) begin
            rd_word = read_success_count;
        end else if (s_axi_araddr[7:2] == `REG_DRIVER_FAILS >> 2) begin
            rd_word = driver_fail_count;
        end else if (s_axi_araddr[7:2] == `REG_FAULT_RANGE >> 2) begin
            rd_word = fault_range_count;
        end else if (s_axi_araddr[7:2] == `REG_RAW >> 2) begin
            rd_word = {8'd0, raw_sample};
        end else if (s_axi_araddr[7:2] == `REG_FILTERED >> 2) begin
            rd_word = {8'd0, filtered_sample};
        end else if (s_axi_araddr[7:2] == `REG_SCALED >> 2) begin
            rd_word = scaled_value;
        end else if (s_axi_araddr[7:2] == `REG_QUALITY >> 2) begin
            rd_word = {26'd0, scaled_q, filt_q, raw_q};
        end else if (s_axi_araddr[7:2] == `REG_FAULT_BITS >> 2) begin
            rd_word = point_fault_bits;
        end else if (s_axi_araddr[7:2] == `REG_LAST_SCAN >> 2) begin
            rd_word = last_scan_time;
        end else begin
            rd_word = 32'h0;
            rd_err = 1'b1;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_err ? 2'b10 : 2'b00;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // analog_input_channel_filter

// ===== sim/aic_monitor.sv
// Purpose: Port timing checks on the channel filter
// Assumes: One aclk domain, synchronous low reset
// Notes: Bound at the foot of this file
`timescale 1ns/1ps
module aic_monitor (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire sample_req,
    input wire module_present_pin
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence aw_w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_w_answer: assert property (aw_w_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("bvalid timing");
    chk_r_answer: assert property (ar_taken |=> s_axi_rvalid)
        else $error("rvalid timing");
    chk_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
        else $error("write not closed");
    chk_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read not closed");
    chk_b_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write ready while busy");
    chk_r_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read ready while busy");
    chk_req_pulse: assert property (sample_req |=> !sample_req)
        else $error("request too long");
    chk_req_absent: assert property (!module_present_pin [*4] |-> !sample_req)
        else $error("request without module");
endmodule // aic_monitor
bind analog_input_channel_filter aic_monitor u_mon (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .sample_req,
    .module_present_pin);

// ===== sim/sample_partner.sv
// Purpose: Behavioural analog input module
// Assumes: Shares aclk with the filter
// Notes: Reply delay follows data bits, so prompt and slow answers occur
`timescale 1ns/1ps
module sample_partner (
    input wire aclk,
    input wire sample_req,
    input wire [23:0] data_in,
    input wire ok_in,
    output reg sample_done = 1'h0,
    output reg sample_ok = 1'h0,
    output reg [23:0] sample_data = 24'h0
);
    reg busy = 1'h0;
    reg [2:0] wait_cnt = 3'h0;
    always @(posedge aclk) begin
        sample_done <= 1'h0;
        if (sample_done)
            sample_data <= ~sample_data; // Not held past done
        if (sample_req) begin
            busy <= 1'h1;
            wait_cnt <= data_in[4:2];
        end else if (busy && wait_cnt != 3'h0) begin
            wait_cnt <= wait_cnt - 3'h1;
        end else if (busy) begin
            busy <= 1'h0;
            sample_done <= 1'h1;
            sample_ok <= ok_in;
            sample_data <= data_in;
        end
    end
endmodule // sample_partner

// ===== sim/tb_top.sv
// Purpose: Register level tests of the channel filter
// Assumes: 4 cycles per ms, 5 ms range hold
// Notes: Samples repeat every four, so each filter set is alike
`timescale 1ns/1ps
module tb_top;
    reg aclk = 1'h0, aresetn = 1'h0, ok_in = 1'h1;
    reg [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    reg [31:0] s_axi_wdata = 32'h0, d, t_scan;
    reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    reg module_present_pin = 1'h1, cal_error_pin = 1'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire sample_req, sample_done, sample_ok;
    wire [23:0] sample_data, data_in;
    reg [23:0] vals [0:3];
    integer err_count = 0, n_compared = 0, idx = 0, m;
    always #25 aclk = ~aclk;
    always @(posedge aclk) if (sample_done) idx <= idx + 1;
    assign data_in = idx < 12 ? vals[idx % 4] : 24'h0007d0;
    analog_input_channel_filter #(.TICK_CYCLES(4), .RANGE_HOLD_MS(5)) dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_req, .sample_done,
        .sample_ok, .sample_data, .module_present_pin, .cal_error_pin);
    sample_partner far_end (.aclk, .sample_req, .data_in, .ok_in, .sample_done,
        .sample_ok, .sample_data);
    task wr(input [7:0] a, input [31:0] v);
        reg aw, w;
        aw = 1'h0;
        w = 1'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(aw && w)) begin
            @(posedge aclk);
            aw = aw | s_axi_awready;
            w = w | s_axi_wready;
            if (aw) s_axi_awvalid <= 1'h0;
            if (w) s_axi_wvalid <= 1'h0;
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
    endtask
    task rd(input [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        s_axi_rready <= 1'h0;
    endtask
    task chk(input [7:0] a, input [31:0] e);
        rd(a);
        n_compared = n_compared + 1;
        if (d !== e) begin
            err_count = err_count + 1;
            $display("[ERR] %0t addr %h got %h want %h", $time, a, d, e);
        end
    endtask
    task poll(input [7:0] a, input [31:0] e);
        integer i;
        rd(a);
        for (i = 0; i < 200 && d !== e; i = i + 1) begin
            repeat (20) @(posedge aclk);
            rd(a);
        end
    endtask
    task test_done;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        vals[0] = 24'h001388;
        vals[1] = 24'h002328;
        vals[2] = 24'h001b58;
        vals[3] = 24'h0032c8;
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        chk(8'h00, 32'h00000101);
        chk(8'h04, 32'h00000064);
        chk(8'h14, 32'h00000009);
        chk(8'h40, 32'h00000000);
        $display("reset values done");
        wr(8'h0c, 32'h00000640);
        for (m = 0; m < 3; m = m + 1) begin
            wr(8'h00, 32'h00000412 | (m << 2));
            poll(8'h1c, 4 * m + 4);
            chk(8'h2c, m == 0 ? 32'h1f40 : m == 1 ? 32'h2134 : 32'h2580);
            chk(8'h30, m == 0 ? 32'h0190 : m == 1 ? 32'h01c2 : 32'h0230);
            if (m > 0) chk(8'h3c, t_scan + 32'd400);
            rd(8'h3c);
            t_scan = d;
            $display("filter mode %0d done", m);
        end
        chk(8'h28, 32'h000032c8);
        cal_error_pin <= 1'h1;
        ok_in <= 1'h0;
        wr(8'h00, 32'h00000116);
        poll(8'h20, 32'h00000001);
        ok_in <= 1'h1;
        poll(8'h1c, 32'h0000000d);
        repeat (40) @(posedge aclk);
        chk(8'h20, 32'h00000001);
        chk(8'h18, 32'h0000000e);
        chk(8'h24, 32'h00000001);
        chk(8'h2c, 32'h000007d0);
        chk(8'h30, 32'hffffff38);
        chk(8'h38, 32'h00002800);
        chk(8'h34, 32'h0000003c);
        $display("range and counts done");
        wr(8'h10, 32'h00000007);
        chk(8'h10, 32'h00000005);
        wr(8'h10, 32'h00000002);
        repeat (2) @(posedge aclk);
        chk(8'h10, 32'h00000002);
        chk(8'h38, 32'h00002000);
        wr(8'h00, 32'h00000115);
        repeat (4) @(posedge aclk);
        chk(8'h34, 32'h0000002a);
        module_present_pin <= 1'h0;
        repeat (4) @(posedge aclk);
        chk(8'h34, 32'h00000015);
        $display("commands and quality done");
        test_done;
    end
    initial begin
        #3000000;
        err_count = err_count + 1;
        $display("[ERR] %0t watchdog expired", $time);
        test_done;
    end
endmodule // tb_top
